// >>> hw/gpc_conversion_control.sv
// General-purpose ADC conversion control with AXI4-Lite registers
// Functional notes
// R1: Soft conversion needs mode, channel, start bit
// R2: Channel 0 gets programmed current source
// R3: Converter powered on demand, or forced on
// R4: Soft done interrupt gated by its mask
// R5: Soft done sets flag, updates result
// R6: Limit uses same 12-bit code as result
// R7: Each slot repeats conversions at programmed rate
// R8: Polarity picks above or below limit
// R9: Slot shutdown enable requests switch-off too
// R10: Each slot interrupt has its own mask
// R11: Slot limit crossing sets its status flag
// R12: Slot latest result in high/low registers
// R13: Switch off after delay unless flag cleared
// R14: Second slot mirrors the first
// R15: Result 12 bits, high nibble plus low byte
// R16: Flags sticky; clearing cancels pending shutdown
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_conversion_control
  import gpc_pkg::*;
#(
  parameter int TICK_CYC   = `GPC_TICK_CYC,
  parameter int SETTLE_CYC = `GPC_SETTLE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        adc_done,
  input  wire gpc_code_t   adc_data,
  output logic             adc_power_on,
  output logic             adc_start,
  output logic [3:0]       adc_channel,
  output logic [1:0]       adc_current_sel,
  output logic             irq,
  output logic             shutdown_req
);
  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam int SET_W  = $clog2(SETTLE_CYC + 1);

  // Register state
  logic [3:0]       soft_channel_select;
  logic             soft_mode_enable;
  logic             soft_pend_r;
  logic             adc_force_on;
  logic [1:0]       cur_src_r;
  logic [2:0]       mask_r;
  logic [2:0]       status_r;
  gpc_code_t        soft_res_r;
  logic [1:0][3:0]  slot_ch_r;
  logic [1:0]       slot_en_r;
  logic [1:0]       slot_sd_r;
  logic [1:0][7:0]  rate_r;
  logic [1:0][11:0] lim_r;
  logic [1:0]       pol_r;
  logic [15:0]      switch_off_delay;

  // Bus and engine state
  logic [7:0]       aw_addr_r;
  logic [15:0]      wdata_r;
  logic [1:0]       wstrb_r;
  logic             do_write;
  logic [31:0]      rd_val;
  logic             rd_ok;
  logic             wr_ok;
  gpc_state_t       state_r;
  gpc_src_t         src_r;
  logic [SET_W-1:0] settle_cnt_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic             tick;
  logic             done_s1, done_s2, done_s3;
  gpc_code_t        data_s1, data_s2;
  logic             conv_done;
  logic             pick_soft, pick_a, pick_b;
  logic [3:0]       pick_ch;
  logic [1:0]       slot_req, slot_hit, slot_fire, slot_gnt, slot_done;
  gpc_code_t        slot_res [2];
  logic [2:0]       stat_clr;
  logic [2:0]       stat_set;

  // Byte-lane merge for registers up to 16 bits wide
  function automatic logic [15:0] gpc_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
    gpc_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                 strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // Offset of a per-slot register
  function automatic logic [7:0] gpc_slot_ofs(input logic [7:0] base, input int s);
    gpc_slot_ofs = 8'(base + s * `GPC_SLOT_STRIDE);
  endfunction

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = do_write && (aw_addr_r == ofs);
  endfunction

  // AXI write: address and data taken in either order, response after both
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPC_RESP_OKAY;
      aw_addr_r     <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata[15:0];
        wstrb_r      <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable offsets; anything else answers with an error
  always_comb begin
    wr_ok = 1'b0;
    case (aw_addr_r)
      `GPC_OFS_SOFT_SEL, `GPC_OFS_CTRL_ONE, `GPC_OFS_IRQ_MASK, `GPC_OFS_IRQ_STAT,
      `GPC_OFS_AUTO_CH, `GPC_OFS_AUTO_CTRL, `GPC_OFS_RATE, `GPC_OFS_SWITCH_OFF_DELAY:
        wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    for (int s = 0; s < 2; s++) begin
      if (aw_addr_r == gpc_slot_ofs(`GPC_OFS_LIM_HI_A, s) ||
          aw_addr_r == gpc_slot_ofs(`GPC_OFS_LIM_LO_A, s))
        wr_ok = 1'b1;
    end
  end

  // AXI read: one access at a time, result registers are read only
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `GPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Read mux; result split is high nibble and low byte
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `GPC_OFS_SOFT_SEL:  rd_val = {24'h0, soft_mode_enable, 2'h0, soft_pend_r,
                                    soft_channel_select};
      `GPC_OFS_CTRL_ONE:  rd_val = {29'h0, cur_src_r, adc_force_on};
      `GPC_OFS_IRQ_MASK:  rd_val = {29'h0, mask_r};
      `GPC_OFS_IRQ_STAT:  rd_val = {29'h0, status_r};
      `GPC_OFS_SOFT_HI:   rd_val = {28'h0, soft_res_r[11:8]}; // [R15]
      `GPC_OFS_SOFT_LO:   rd_val = {24'h0, soft_res_r[7:0]};
      `GPC_OFS_AUTO_CH:   rd_val = {24'h0, slot_ch_r[1], slot_ch_r[0]};
      `GPC_OFS_AUTO_CTRL: rd_val = {28'h0, slot_sd_r, slot_en_r};
      `GPC_OFS_RATE:      rd_val = {16'h0, rate_r[1], rate_r[0]};
      `GPC_OFS_SWITCH_OFF_DELAY: rd_val = {16'h0, switch_off_delay};
      default:            rd_ok  = 1'b0;
    endcase
    for (int s = 0; s < 2; s++) begin
      if (s_axi_araddr == gpc_slot_ofs(`GPC_OFS_LIM_HI_A, s)) begin
        rd_val = {24'h0, pol_r[s], 3'h0, lim_r[s][11:8]};
        rd_ok  = 1'b1;
      end
      if (s_axi_araddr == gpc_slot_ofs(`GPC_OFS_LIM_LO_A, s)) begin
        rd_val = {24'h0, lim_r[s][7:0]};
        rd_ok  = 1'b1;
      end
      if (s_axi_araddr == gpc_slot_ofs(`GPC_OFS_RES_HI_A, s)) begin
        rd_val = {28'h0, slot_res[s][11:8]}; // [R12]
        rd_ok  = 1'b1;
      end
      if (s_axi_araddr == gpc_slot_ofs(`GPC_OFS_RES_LO_A, s)) begin
        rd_val = {24'h0, slot_res[s][7:0]};
        rd_ok  = 1'b1;
      end
    end
  end

  // Soft select; start only taken when the same write also sets the mode enable bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      soft_mode_enable    <= 1'b0;
      soft_channel_select <= '0;
      soft_pend_r         <= 1'b0;
    end else begin
      if (pick_soft)
        soft_pend_r <= 1'b0;
      if (wr_hit(`GPC_OFS_SOFT_SEL) && wstrb_r[0]) begin
        soft_mode_enable    <= wdata_r[`GPC_SOFT_EN_BIT];
        soft_channel_select <= wdata_r[3:0];
        if (wdata_r[`GPC_SOFT_START_BIT] && wdata_r[`GPC_SOFT_EN_BIT])
          soft_pend_r <= 1'b1; // [R1]
      end
    end
  end

  // Converter control, masks, auto configuration and delay
  always_ff @(posedge mclk) begin
    if (reset) begin
      adc_force_on     <= 1'b0;
      cur_src_r        <= '0;
      mask_r           <= `GPC_MASK_RST;
      slot_ch_r        <= '0;
      slot_en_r        <= '0;
      slot_sd_r        <= '0;
      rate_r           <= {2{`GPC_RATE_RST}};
      switch_off_delay <= `GPC_DLY_RST;
    end else begin
      if (wr_hit(`GPC_OFS_CTRL_ONE) && wstrb_r[0]) begin
        adc_force_on <= wdata_r[`GPC_FORCE_BIT];
        cur_src_r    <= wdata_r[`GPC_CUR_LSB +: 2];
      end
      if (wr_hit(`GPC_OFS_IRQ_MASK) && wstrb_r[0])
        mask_r <= wdata_r[2:0];
      if (wr_hit(`GPC_OFS_AUTO_CH) && wstrb_r[0])
        slot_ch_r <= wdata_r[7:0];
      if (wr_hit(`GPC_OFS_AUTO_CTRL) && wstrb_r[0]) begin
        slot_en_r <= wdata_r[1:0];
        slot_sd_r <= wdata_r[`GPC_SD_LSB +: 2];
      end
      if (wr_hit(`GPC_OFS_RATE))
        rate_r <= gpc_merge(rate_r, wdata_r, wstrb_r);
      if (wr_hit(`GPC_OFS_SWITCH_OFF_DELAY))
        switch_off_delay <= gpc_merge(switch_off_delay, wdata_r, wstrb_r);
    end
  end

  // Per-slot limits and slot engines, identical for both slots
  for (genvar s = 0; s < 2; s++) begin : g_slot
    localparam logic [7:0] LIM_HI = gpc_slot_ofs(`GPC_OFS_LIM_HI_A, s);
    localparam logic [7:0] LIM_LO = gpc_slot_ofs(`GPC_OFS_LIM_LO_A, s);

    // Limit code shares the 12-bit result scale
    always_ff @(posedge mclk) begin
      if (reset) begin
        lim_r[s] <= '0;
        pol_r[s] <= 1'b0;
      end else begin
        if (wr_hit(LIM_HI) && wstrb_r[0]) begin
          lim_r[s][11:8] <= wdata_r[3:0]; // [R6]
          pol_r[s]       <= wdata_r[`GPC_POL_BIT];
        end
        if (wr_hit(LIM_LO) && wstrb_r[0])
          lim_r[s][7:0] <= wdata_r[7:0];
      end
    end

    gpc_slot u_slot (
      .mclk          (mclk),
      .reset         (reset),
      .tick          (tick),
      .enable        (slot_en_r[s]),
      .rate          (rate_r[s]),
      .limit         (lim_r[s]),
      .polarity      (pol_r[s]),
      .shutdown_en   (slot_sd_r[s]),
      .delay         (switch_off_delay),
      .granted       (slot_gnt[s]),
      .done          (slot_done[s]),
      .result_in     (data_s2),
      .flag_clear    (stat_clr[`GPC_IRQ_SLOT_LSB + s]),
      .req           (slot_req[s]),
      .hit           (slot_hit[s]),
      .result        (slot_res[s]),
      .shutdown_fire (slot_fire[s])
    ); // [R14]
  end

  // Slow time base for rates and shutdown delay
  assign tick = (tick_cnt_r == TICK_W'(TICK_CYC - 1));
  always_ff @(posedge mclk) begin
    if (reset || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  // End-of-conversion and data come from the analog side: three flops on done, two on data
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      done_s1 <= adc_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      data_s1 <= adc_data;
      data_s2 <= data_s1;
    end
  end
  assign conv_done = (state_r == st_wait) && done_s2 && !done_s3;

  // Arbitration: software first, then slot a, then slot b
  assign pick_soft = (state_r == st_idle) && soft_pend_r;
  assign pick_a    = (state_r == st_idle) && !soft_pend_r && slot_req[0];
  assign pick_b    = (state_r == st_idle) && !soft_pend_r && !slot_req[0] && slot_req[1];
  assign pick_ch   = pick_soft ? soft_channel_select : (pick_a ? slot_ch_r[0] : slot_ch_r[1]);
  assign slot_gnt  = {pick_b, pick_a};
  assign slot_done = {conv_done && src_r == src_b, conv_done && src_r == src_a};

  // Conversion sequencer; settling skipped while power is still up
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r         <= st_idle;
      src_r           <= src_soft;
      settle_cnt_r    <= '0;
      adc_start       <= 1'b0;
      adc_channel     <= '0;
      adc_current_sel <= '0;
    end else begin
      adc_start <= 1'b0;
      case (state_r)
        st_idle: begin
          if (pick_soft || pick_a || pick_b) begin
            src_r           <= pick_soft ? src_soft : (pick_a ? src_a : src_b);
            adc_channel     <= pick_ch;
            adc_current_sel <= (pick_ch == 4'h0) ? cur_src_r : 2'h0; // [R2]
            settle_cnt_r    <= SET_W'(SETTLE_CYC - 1);
            state_r         <= adc_power_on ? st_start : st_settle;
          end
        end
        st_settle: begin
          if (settle_cnt_r == '0)
            state_r <= st_start;
          else
            settle_cnt_r <= settle_cnt_r - 1'b1;
        end
        st_start: begin
          adc_start <= 1'b1;
          state_r   <= st_wait;
        end
        st_wait: begin
          if (conv_done)
            state_r <= st_idle;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // Power from pick until idle, or forced; no drop between back-to-back picks
  always_ff @(posedge mclk) begin
    if (reset)
      adc_power_on <= 1'b0;
    else
      adc_power_on <= adc_force_on || (state_r != st_idle) || pick_soft || |slot_gnt; // [R3]
  end

  // Soft result capture
  always_ff @(posedge mclk) begin
    if (reset)
      soft_res_r <= '0;
    else if (conv_done && src_r == src_soft)
      soft_res_r <= data_s2; // [R5]
  end

  // Sticky status, write one to clear; a new event wins over the clear
  assign stat_clr = (do_write && aw_addr_r == `GPC_OFS_IRQ_STAT && wstrb_r[0]) ?
                    wdata_r[2:0] : 3'h0;
  assign stat_set = {slot_hit, conv_done && src_r == src_soft}; // [R5] [R11]
  always_ff @(posedge mclk) begin
    if (reset)
      status_r <= '0;
    else
      status_r <= (status_r & ~stat_clr) | stat_set; // [R16]
  end

  // Interrupt and shutdown outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq          <= 1'b0;
      shutdown_req <= 1'b0;
    end else begin
      irq          <= |(status_r & ~mask_r); // [R4] [R10]
      shutdown_req <= |slot_fire; // [R13]
    end
  end
endmodule // gpc_conversion_control

// >>> hw/gpc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH
`define GPC_OFS_SOFT_SEL   8'h00
`define GPC_OFS_CTRL_ONE   8'h04
`define GPC_OFS_IRQ_MASK   8'h08
`define GPC_OFS_IRQ_STAT   8'h0c
`define GPC_OFS_SOFT_HI    8'h10
`define GPC_OFS_SOFT_LO    8'h14
`define GPC_OFS_AUTO_CH    8'h18
`define GPC_OFS_AUTO_CTRL  8'h1c
`define GPC_OFS_LIM_HI_A   8'h20
`define GPC_OFS_LIM_LO_A   8'h24
`define GPC_OFS_RES_HI_A   8'h30
`define GPC_OFS_RES_LO_A   8'h34
`define GPC_OFS_RATE       8'h40
`define GPC_OFS_SWITCH_OFF_DELAY  8'h44
`define GPC_SLOT_STRIDE    8'h08
`define GPC_SOFT_START_BIT 4
`define GPC_SOFT_EN_BIT    7
`define GPC_FORCE_BIT      0
`define GPC_CUR_LSB        1
`define GPC_POL_BIT        7
`define GPC_SD_LSB         2
`define GPC_IRQ_SOFT       0
`define GPC_IRQ_SLOT_LSB   1
`define GPC_MASK_RST       3'h7
`define GPC_RATE_RST       8'h0f
`define GPC_DLY_RST        16'h0010
`define GPC_RESP_OKAY      2'b00
`define GPC_RESP_SLVERR    2'b10
`define GPC_CLK_MHZ        100
`define GPC_SETTLE_NS      1000
`define GPC_SETTLE_CYC     ((`GPC_SETTLE_NS * `GPC_CLK_MHZ + 999) / 1000)
`define GPC_TICK_US        1000
`define GPC_TICK_CYC       (`GPC_TICK_US * `GPC_CLK_MHZ)
`endif

// >>> hw/gpc_pkg.sv
// Types shared by the conversion control modules
package gpc_pkg;
  typedef logic [11:0] gpc_code_t;
  typedef enum logic [1:0] {st_idle, st_settle, st_start, st_wait} gpc_state_t;
  typedef enum logic [1:0] {src_soft, src_a, src_b} gpc_src_t;
endpackage

// >>> hw/gpc_slot.sv
// One auto-conversion slot: rate timer, threshold compare, shutdown delay
`timescale 1ns/100ps
module gpc_slot
  import gpc_pkg::*;
#(
  parameter int RATE_W = 8,
  parameter int DLY_W  = 16
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              tick,
  input  wire logic              enable,
  input  wire logic [RATE_W-1:0] rate,
  input  wire gpc_code_t         limit,
  input  wire logic              polarity,
  input  wire logic              shutdown_en,
  input  wire logic [DLY_W-1:0]  delay,
  input  wire logic              granted,
  input  wire logic              done,
  input  wire gpc_code_t         result_in,
  input  wire logic              flag_clear,
  output logic                   req,
  output logic                   hit,
  output gpc_code_t              result,
  output logic                   shutdown_fire
);
  logic [RATE_W-1:0] rate_cnt_r;
  logic [DLY_W-1:0]  dly_cnt_r;
  logic              pend_r;
  logic              beyond;

  // Interval timer; a grant clears the request unless a new one lands
  always_ff @(posedge mclk) begin
    if (reset || !enable) begin
      rate_cnt_r <= '0;
      req        <= 1'b0;
    end else begin
      if (granted)
        req <= 1'b0;
      if (tick) begin
        if (rate_cnt_r == rate) begin // [R7]
          rate_cnt_r <= '0;
          req        <= 1'b1;
        end else begin
          rate_cnt_r <= rate_cnt_r + 1'b1;
        end
      end
    end
  end

  // Polarity high means fire when below the limit
  assign beyond = polarity ? (result_in < limit) : (result_in > limit); // [R8]

  // Latest result and threshold event
  always_ff @(posedge mclk) begin
    if (reset) begin
      result <= '0;
      hit    <= 1'b0;
    end else begin
      hit <= done && enable && beyond; // [R11]
      if (done)
        result <= result_in; // [R12]
    end
  end

  // Shutdown delay; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_r        <= 1'b0;
      dly_cnt_r     <= '0;
      shutdown_fire <= 1'b0;
    end else if (hit && shutdown_en) begin // [R9]
      pend_r    <= 1'b1;
      dly_cnt_r <= delay;
    end else if (flag_clear) begin
      pend_r <= 1'b0; // [R16]
    end else if (pend_r && tick) begin
      if (dly_cnt_r == '0) begin
        shutdown_fire <= 1'b1; // [R13]
        pend_r        <= 1'b0;
      end else begin
        dly_cnt_r <= dly_cnt_r - 1'b1;
      end
    end
  end
endmodule // gpc_slot

// >>> dv/gpc_cc_asserts.sv
// Bus and converter timing checks for the conversion control block
`timescale 1ns/100ps
module gpc_cc_asserts #(
  parameter int TICK_CYC   = 20,
  parameter int SETTLE_CYC = 3
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        adc_start,
  input wire logic        adc_power_on,
  input wire logic [3:0]  adc_channel,
  input wire logic [1:0]  adc_current_sel,
  input wire logic        shutdown_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Answers waiting on a stalled master
  sequence s_bwait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_launch; adc_start ##1 !adc_start; endsequence
  property p_bhold; s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped while stalled");
  property p_rhold; s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data changed while stalled");
  property p_awbusy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_awbusy: assert property (p_awbusy)
    else $error("second write address taken during a write");
  // Current source only reaches channel 0
  property p_cur; adc_current_sel != 2'b00 |-> adc_channel == 4'h0; endproperty
  a_cur: assert property (p_cur)
    else $error("current source on a channel other than 0");
  property p_pow; adc_start |-> adc_power_on && $past(adc_power_on); endproperty
  a_pow: assert property (p_pow)
    else $error("conversion started on an unpowered converter");
  property p_pulse; adc_start |-> s_launch; endproperty
  a_pulse: assert property (p_pulse)
    else $error("start held longer than one cycle");
  property p_chan; adc_start |=> $stable(adc_channel) [*2]; endproperty
  a_chan: assert property (p_chan)
    else $error("channel changed during a conversion");
  property p_shut; shutdown_req |=> shutdown_req; endproperty
  a_shut: assert property (p_shut)
    else $error("switch-off request withdrawn");
endmodule // gpc_cc_asserts

bind gpc_conversion_control gpc_cc_asserts #(.TICK_CYC(TICK_CYC), .SETTLE_CYC(SETTLE_CYC)) u_chk (
  .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .adc_start(adc_start), .adc_power_on(adc_power_on), .adc_channel(adc_channel),
  .adc_current_sel(adc_current_sel), .shutdown_req(shutdown_req));

// >>> dv/testbench.sv
// Self-checking bench for the conversion control block
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module testbench
  import gpc_pkg::*;
;
  logic        mclk, reset, adc_done;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, adc_current_sel, seen_cur;
  logic [31:0] s_axi_rdata;
  logic        adc_power_on, adc_start, irq, shutdown_req;
  logic [3:0]  adc_channel, adc_cnt, seen_ch;
  logic [15:0] ch_seen;
  gpc_code_t   adc_data, conv_val;
  gpc_code_t   lv [2] = '{12'h7ff, 12'h800};
  logic [31:0] ex [2] = '{32'h4, 32'h0};
  int          err_count, checks_done, starts, ns, cycles;

  // Short tick and settle so slot timing fits the run
  gpc_conversion_control #(.TICK_CYC(20), .SETTLE_CYC(3)) dut (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_done(adc_done), .adc_data(adc_data), .adc_power_on(adc_power_on),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_current_sel(adc_current_sel),
    .irq(irq), .shutdown_req(shutdown_req));

  always #5 mclk = ~mclk;

  // Converter stand-in: one-cycle done pulse; data held until the next start
  always @(posedge mclk) begin
    if (adc_start) begin
      adc_data <= conv_val;
      adc_cnt <= 4'd5;
      seen_ch <= adc_channel;
      seen_cur <= adc_current_sel;
      ch_seen[adc_channel] <= 1'b1;
      starts++;
    end else if (adc_cnt != 4'd0) begin
      adc_cnt <= adc_cnt - 4'd1;
    end
    adc_done <= (adc_cnt == 4'd1);
  end

  // Watchdog well above the longest expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Ready is raised only after the answer shows, so stalls are exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask

  // Conversion is done, captured and flagged well within 15 cycles of start
  task automatic wait_start();
    while (starts <= ns) @(posedge mclk);
    repeat (15) @(posedge mclk);
  endtask

  task automatic wait_irq();
    while (irq !== 1'b1) @(posedge mclk);
  endtask

  initial begin
    mclk = 0; reset = 1; adc_done = 0; adc_data = 0; conv_val = 0; adc_cnt = 0; ch_seen = 0;
    s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_araddr = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // Reset values and refused accesses
    rd(8'h08, 32'h7);
    rd(8'h40, 32'h0f0f);
    rd(8'h44, 32'h10);
    rd(8'h0c, 32'h0);
    rd(8'h50, 32'h0, 2'b10);
    wr(8'h34, 32'h5a, 2'b10);
    rd(8'h34, 32'h0);
    $display("registers done");
    // Soft conversion on channel 0 with current source, unmasked
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h6);
    conv_val <= 12'ha5c;
    ns = starts;
    wr(8'h00, 32'h90);
    wait_start();
    `CHK(seen_ch, 4'h0)
    `CHK(seen_cur, 2'h2)
    `CHK(irq, 1'b1)
    `CHK(adc_power_on, 1'b0)
    rd(8'h0c, 32'h1);
    rd(8'h10, 32'ha);
    rd(8'h14, 32'h5c);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0);
    `CHK(irq, 1'b0)
    // Start without mode is ignored; masked done; forced power
    wr(8'h08, 32'h7);
    wr(8'h04, 32'h5);
    ns = starts;
    wr(8'h00, 32'h13);
    repeat (30) @(posedge mclk);
    `CHK(starts, ns)
    `CHK(adc_power_on, 1'b1)
    wr(8'h00, 32'h93);
    wait_start();
    `CHK(seen_ch, 4'h3)
    `CHK(seen_cur, 2'h0)
    `CHK(irq, 1'b0)
    rd(8'h0c, 32'h1);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h1);
    `CHK(adc_power_on, 1'b0)
    $display("soft done");
    // Both slots: a above 0x800 every tick, b below 0x800 every 2 ticks
    wr(8'h40, 32'h0100);
    wr(8'h18, 32'h65);
    wr(8'h20, 32'h08);
    wr(8'h24, 32'h00);
    wr(8'h28, 32'h88);
    wr(8'h2c, 32'h00);
    wr(8'h08, 32'h1);
    conv_val <= 12'h900;
    wr(8'h1c, 32'h3);
    repeat (150) @(posedge mclk);
    `CHK(ch_seen[6:5], 2'b11)
    `CHK(irq, 1'b1)
    rd(8'h0c, 32'h2);
    rd(8'h30, 32'h9);
    rd(8'h38, 32'h9);
    rd(8'h3c, 32'h0);
    // Just below the limit hits b only; exactly at it hits neither
    foreach (lv[i]) begin
      conv_val <= lv[i];
      repeat (60) @(posedge mclk);
      wr(8'h0c, 32'h7);
      repeat (100) @(posedge mclk);
      rd(8'h0c, ex[i]);
    end
    $display("slots done");
    // Switch-off: cleared in time is cancelled, left alone it fires
    wr(8'h1c, 32'h0);
    wr(8'h40, 32'hff);
    wr(8'h44, 32'h3);
    conv_val <= 12'h900;
    wr(8'h0c, 32'h7);
    wr(8'h1c, 32'h5);
    wait_irq();
    wr(8'h0c, 32'h2);
    repeat (150) @(posedge mclk);
    `CHK(shutdown_req, 1'b0)
    wait_irq();
    repeat (40) @(posedge mclk);
    `CHK(shutdown_req, 1'b0)
    repeat (60) @(posedge mclk);
    `CHK(shutdown_req, 1'b1)
    $display("shutdown done");
    end_of_test();
  end
endmodule // testbench
